// file: pkg/cmts_pkg.sv
// Constants, register map and types of the control mode and torque limit selector.
// Assumes one 50 MHz clock and Avalon-MM word addressing on the register port.
package cmts_pkg;

  localparam int DATA_W       = 32;
  localparam int ADDR_W       = 4;
  localparam int LIM_W        = 10;
  localparam int TREQ_W       = 12;
  localparam int NUM_IN_TERM  = 6;
  localparam int NUM_OUT_TERM = 3;
  localparam int TIDX_W       = 3;
  localparam int NUM_FUNC     = 6;
  localparam int SYNC_STAGES  = 2;

  // Logical input functions, each mapped to one physical terminal or to none
  localparam int FN_FWD = 0;
  localparam int FN_REV = 1;
  localparam int FN_MSW = 2;
  localparam int FN_ALT = 3;
  localparam int FN_SPA = 4;
  localparam int FN_SPB = 5;

  // Word addresses
  localparam logic [ADDR_W-1:0] REG_BASIC_FUNC = 4'h0;
  localparam logic [ADDR_W-1:0] REG_SPEED_OPT  = 4'h1;
  localparam logic [ADDR_W-1:0] REG_INPUT_MAP  = 4'h2;
  localparam logic [ADDR_W-1:0] REG_SPSEL_MAP  = 4'h3;
  localparam logic [ADDR_W-1:0] REG_OUTPUT_MAP = 4'h4;
  localparam logic [ADDR_W-1:0] REG_FWD_INT    = 4'h5;
  localparam logic [ADDR_W-1:0] REG_REV_INT    = 4'h6;
  localparam logic [ADDR_W-1:0] REG_FWD_EXT    = 4'h7;
  localparam logic [ADDR_W-1:0] REG_REV_EXT    = 4'h8;
  localparam logic [ADDR_W-1:0] REG_STATE      = 4'h9;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT   = 4'ha;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK   = 4'hb;
  localparam logic [ADDR_W-1:0] REG_FWD_ACT    = 4'hc;
  localparam logic [ADDR_W-1:0] REG_REV_ACT    = 4'hd;

  // Field positions
  localparam int MAP_NIB_W    = 4;
  localparam int ST_MODE_POS  = 0;
  localparam int ST_LIM_POS   = 4;
  localparam int ST_FUNC_POS  = 8;
  localparam int IRQ_LIM_BIT  = 0;
  localparam int IRQ_MODE_BIT = 1;
  localparam int IRQ_W        = 2;

  // Reset values
  localparam logic [3:0]        MODE_PAIR_RST = 4'h7;
  localparam logic [1:0]        SPEED_OPT_RST = 2'h0;
  localparam logic [15:0]       IN_MAP_RST    = 16'h7021;
  localparam logic [7:0]        SP_MAP_RST    = 8'h77;
  localparam logic [1:0]        OUT_MAP_RST   = 2'h0;
  localparam logic [LIM_W-1:0]  LIM_MAX       = 10'h320;
  localparam logic [LIM_W-1:0]  INT_LIM_RST   = 10'h320;
  localparam logic [LIM_W-1:0]  EXT_LIM_RST   = 10'h064;

  // Mode pair codes
  localparam logic [3:0] PAIR_ISPD_SPD  = 4'h4;
  localparam logic [3:0] PAIR_ISPD_POS  = 4'h5;
  localparam logic [3:0] PAIR_ISPD_TRQ  = 4'h6;
  localparam logic [3:0] PAIR_POS_SPD   = 4'h7;
  localparam logic [3:0] PAIR_POS_TRQ   = 4'h8;
  localparam logic [3:0] PAIR_TRQ_SPD   = 4'h9;
  localparam logic [3:0] PAIR_SPD_ZCLMP = 4'ha;
  localparam logic [3:0] PAIR_POS_INH   = 4'hb;

  localparam logic [1:0] SPEED_OPT_ANALOG_GATED = 2'h3;

  typedef enum logic [2:0] {
    MODE_INT_SPEED,
    MODE_SPEED,
    MODE_POSITION,
    MODE_TORQUE,
    MODE_ZERO_CLAMP,
    MODE_INHIBIT
  } cmts_mode_type;

endpackage

// file: hw/cmts_sync.sv
// Two-stage synchroniser for a bus of independent level inputs.
// Assumes the inputs are asynchronous pins; reset value is the inactive high level.
`timescale 1ns/1ps
`default_nettype none
module cmts_sync
  import cmts_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_r;
    always_ff @(posedge clk) begin
      if (rst) begin
        meta_r  <= 1'b1;
        dout[i] <= 1'b1;
      end else begin
        meta_r  <= din[i];
        dout[i] <= meta_r;
      end
    end
  end

endmodule // cmts_sync
`default_nettype wire

// file: hw/cmts_limit_select.sv
// Torque limit selection, torque-limited status and control mode selection.
// Assumes asynchronous active-low terminals, an analog limit and torque request
// already on clk, and an Avalon-MM master on the register port.
//
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Forward select low: forward limit is min of analog, internal, external.
// - Forward select high: forward limit is the internal parameter only.
// - Reverse select low: reverse limit is min of analog, internal, external.
// - Reverse select high: reverse limit is the internal parameter only.
// - Functions sharing one terminal all see that terminal's state.
// - Torque-limited output low while torque is clamped, high otherwise.
// - Torque-limited output reaches a terminal only when mapped; default none.
// - Mode pair codes 4 to B select the documented pairs of modes.
// - Codes 4-6: both limit selects high leave internal speed control.
// - Mapped speed select inputs replace limit selects for internal speed switching.
// - Codes 7-B, switch low: speed, torque, speed, zero clamp, inhibit.
// - Codes 7-B, switch high: position, position, torque, speed, position.
// - Mode switch or alternate select both switch modes identically.
// - Limit parameters hold 0 to 800 percent and act on the next cycle.
// - Analog limit joins selection only when the speed option gates it.
module cmts_limit_select
  import cmts_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic [ADDR_W-1:0]        avsAddress,
  input  wire logic                     avsRead,
  input  wire logic                     avsWrite,
  input  wire logic [DATA_W-1:0]        avsWritedata,
  input  wire logic [3:0]               avsByteenable,
  output var  logic [DATA_W-1:0]        avsReaddata,
  output var  logic                     avsWaitrequest,
  input  wire logic [NUM_IN_TERM-1:0]   inTermN,
  input  wire logic [LIM_W-1:0]         analogLimit,
  input  wire logic signed [TREQ_W-1:0] torqueReq,
  output var  logic [LIM_W-1:0]         fwdTorqueLimit,
  output var  logic [LIM_W-1:0]         revTorqueLimit,
  output var  cmts_mode_type            activeMode,
  output var  logic                     torqueLimitedN,
  output var  logic [NUM_OUT_TERM-1:0]  outTermN,
  output var  logic                     irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [3:0]             modePair_r;
  logic [1:0]             speedOpt_r;
  logic [15:0]            inMap_r;
  logic [7:0]             spdMap_r;
  logic [1:0]             outMap_r;
  logic [LIM_W-1:0]       fwdInt_r;
  logic [LIM_W-1:0]       revInt_r;
  logic [LIM_W-1:0]       fwdExt_r;
  logic [LIM_W-1:0]       revExt_r;
  logic [IRQ_W-1:0]       irqStat_r;
  logic [IRQ_W-1:0]       irqMask_r;
  logic [IRQ_W-1:0]       irqEvt;
  logic [IRQ_W-1:0]       irqClr;
  logic [NUM_IN_TERM-1:0] termSync;
  logic [TIDX_W-1:0]      funcIdx [NUM_FUNC];
  logic [NUM_FUNC-1:0]    funcOn;
  logic                   analogUse;
  logic                   spdMapped;
  logic [LIM_W-1:0]       fwdLimit_nxt;
  logic [LIM_W-1:0]       revLimit_nxt;
  cmts_mode_type          mode_nxt;
  logic                   reqNeg;
  logic [TREQ_W-1:0]      reqMag;
  logic                   limited_nxt;
  logic                   accept;
  logic                   done;
  logic                   wrEn;
  logic [DATA_W-1:0]      rdMux;
  logic [DATA_W-1:0]      beMask;

  function automatic logic [LIM_W-1:0] minLim(input logic [LIM_W-1:0] a,
                                               input logic [LIM_W-1:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic logic [LIM_W-1:0] clampLim(input logic [DATA_W-1:0] v);
    return (v > DATA_W'(LIM_MAX)) ? LIM_MAX : v[LIM_W-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input terminals

  cmts_sync #(
    .W    (NUM_IN_TERM)
  ) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (inTermN),
    .dout (termSync)
  );

  assign funcIdx[FN_FWD] = inMap_r[0*MAP_NIB_W +: TIDX_W];
  assign funcIdx[FN_REV] = inMap_r[1*MAP_NIB_W +: TIDX_W];
  assign funcIdx[FN_MSW] = inMap_r[2*MAP_NIB_W +: TIDX_W];
  assign funcIdx[FN_ALT] = inMap_r[3*MAP_NIB_W +: TIDX_W];
  assign funcIdx[FN_SPA] = spdMap_r[0*MAP_NIB_W +: TIDX_W];
  assign funcIdx[FN_SPB] = spdMap_r[1*MAP_NIB_W +: TIDX_W];

  // each function reads its terminal, shared terminals alike
  for (genvar i = 0; i < NUM_FUNC; i++) begin : g_func
    assign funcOn[i] = (funcIdx[i] < NUM_IN_TERM) ? ~termSync[funcIdx[i]] : 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Torque limit selection

  // analog limit only when gated by the speed option
  assign analogUse = (speedOpt_r == SPEED_OPT_ANALOG_GATED);

  always_comb begin
    fwdLimit_nxt = fwdInt_r;
    revLimit_nxt = revInt_r;
    // forward select active takes the smallest
    if (funcOn[FN_FWD]) begin
      fwdLimit_nxt = minLim(fwdInt_r, fwdExt_r);
      if (analogUse) begin
        fwdLimit_nxt = minLim(fwdLimit_nxt, analogLimit);
      end
    end
    // reverse select active takes the smallest
    if (funcOn[FN_REV]) begin
      revLimit_nxt = minLim(revInt_r, revExt_r);
      if (analogUse) begin
        revLimit_nxt = minLim(revLimit_nxt, analogLimit);
      end
    end
  end

  // internal limit alone while selects are high
  always_ff @(posedge clk) begin
    if (rst) begin
      fwdTorqueLimit <= INT_LIM_RST;
      revTorqueLimit <= INT_LIM_RST;
    end else begin
      fwdTorqueLimit <= fwdLimit_nxt;
      revTorqueLimit <= revLimit_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Torque-limited status

  assign reqNeg = torqueReq[TREQ_W-1];
  assign reqMag = reqNeg ? TREQ_W'(-torqueReq) : TREQ_W'(torqueReq);
  assign limited_nxt = reqNeg ? (reqMag > TREQ_W'(revTorqueLimit))
                              : (reqMag > TREQ_W'(fwdTorqueLimit));

  // low while the request is clamped
  always_ff @(posedge clk) begin
    if (rst) begin
      torqueLimitedN <= 1'b1;
    end else begin
      torqueLimitedN <= ~limited_nxt;
    end
  end

  // only a mapped terminal carries the status
  for (genvar j = 0; j < NUM_OUT_TERM; j++) begin : g_out
    always_ff @(posedge clk) begin
      if (rst) begin
        outTermN[j] <= 1'b1;
      end else begin
        outTermN[j] <= ~(limited_nxt && (outMap_r == 2'(j + 1)));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control mode selection

  assign spdMapped = (funcIdx[FN_SPA] < NUM_IN_TERM) || (funcIdx[FN_SPB] < NUM_IN_TERM);

  always_comb begin
    logic swOn;
    logic bothHigh;
    swOn     = funcOn[FN_MSW] | funcOn[FN_ALT];
    bothHigh = spdMapped ? !(funcOn[FN_SPA] | funcOn[FN_SPB])
                         : !(funcOn[FN_FWD] | funcOn[FN_REV]);
    mode_nxt = MODE_INHIBIT;
    case (modePair_r)
      PAIR_ISPD_SPD:  mode_nxt = bothHigh ? MODE_SPEED : MODE_INT_SPEED;
      PAIR_ISPD_POS:  mode_nxt = bothHigh ? MODE_POSITION : MODE_INT_SPEED;
      PAIR_ISPD_TRQ:  mode_nxt = bothHigh ? MODE_TORQUE : MODE_INT_SPEED;
      PAIR_POS_SPD:   mode_nxt = swOn ? MODE_SPEED : MODE_POSITION;
      PAIR_POS_TRQ:   mode_nxt = swOn ? MODE_TORQUE : MODE_POSITION;
      PAIR_TRQ_SPD:   mode_nxt = swOn ? MODE_SPEED : MODE_TORQUE;
      PAIR_SPD_ZCLMP: mode_nxt = swOn ? MODE_ZERO_CLAMP : MODE_SPEED;
      PAIR_POS_INH:   mode_nxt = swOn ? MODE_INHIBIT : MODE_POSITION;
      default:        mode_nxt = MODE_INHIBIT;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      activeMode <= MODE_INHIBIT;
    end else begin
      activeMode <= mode_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus: one wait cycle for every access

  assign accept = (avsRead | avsWrite) & avsWaitrequest;
  assign done   = (avsRead | avsWrite) & ~avsWaitrequest;
  assign wrEn   = avsWrite & done;
  assign beMask = {{8{avsByteenable[3]}}, {8{avsByteenable[2]}},
                   {8{avsByteenable[1]}}, {8{avsByteenable[0]}}};

  always_ff @(posedge clk) begin
    if (rst) begin
      avsWaitrequest <= 1'b1;
    end else begin
      avsWaitrequest <= ~accept;
    end
  end

  always_comb begin
    rdMux = '0;
    case (avsAddress)
      REG_BASIC_FUNC: rdMux = DATA_W'(modePair_r);
      REG_SPEED_OPT:  rdMux = DATA_W'(speedOpt_r);
      REG_INPUT_MAP:  rdMux = DATA_W'(inMap_r);
      REG_SPSEL_MAP:  rdMux = DATA_W'(spdMap_r);
      REG_OUTPUT_MAP: rdMux = DATA_W'(outMap_r);
      REG_FWD_INT:    rdMux = DATA_W'(fwdInt_r);
      REG_REV_INT:    rdMux = DATA_W'(revInt_r);
      REG_FWD_EXT:    rdMux = DATA_W'(fwdExt_r);
      REG_REV_EXT:    rdMux = DATA_W'(revExt_r);
      REG_STATE: begin
        rdMux[ST_MODE_POS +: 3]        = activeMode;
        rdMux[ST_LIM_POS]              = ~torqueLimitedN;
        rdMux[ST_FUNC_POS +: NUM_FUNC] = funcOn;
      end
      REG_IRQ_STAT:   rdMux = DATA_W'(irqStat_r);
      REG_IRQ_MASK:   rdMux = DATA_W'(irqMask_r);
      REG_FWD_ACT:    rdMux = DATA_W'(fwdTorqueLimit);
      REG_REV_ACT:    rdMux = DATA_W'(revTorqueLimit);
      default:        rdMux = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      avsReaddata <= '0;
    end else if (accept) begin
      avsReaddata <= avsRead ? rdMux : '0;
    end
  end

  // Mode and mapping configuration
  always_ff @(posedge clk) begin
    if (rst) begin
      modePair_r <= MODE_PAIR_RST;
      speedOpt_r <= SPEED_OPT_RST;
      inMap_r    <= IN_MAP_RST;
      spdMap_r   <= SP_MAP_RST;
      outMap_r   <= OUT_MAP_RST;
    end else if (wrEn) begin
      case (avsAddress)
        REG_BASIC_FUNC: modePair_r <= 4'((DATA_W'(modePair_r) & ~beMask) | (avsWritedata & beMask));
        REG_SPEED_OPT:  speedOpt_r <= 2'((DATA_W'(speedOpt_r) & ~beMask) | (avsWritedata & beMask));
        REG_INPUT_MAP:  inMap_r <= 16'((DATA_W'(inMap_r) & ~beMask) | (avsWritedata & beMask));
        REG_SPSEL_MAP:  spdMap_r <= 8'((DATA_W'(spdMap_r) & ~beMask) | (avsWritedata & beMask));
        REG_OUTPUT_MAP: outMap_r <= 2'((DATA_W'(outMap_r) & ~beMask) | (avsWritedata & beMask));
        default: ;
      endcase
    end
  end

  // limits clamp to 800 and act on the next cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      fwdInt_r <= INT_LIM_RST;
      revInt_r <= INT_LIM_RST;
      fwdExt_r <= EXT_LIM_RST;
      revExt_r <= EXT_LIM_RST;
    end else if (wrEn) begin
      case (avsAddress)
        REG_FWD_INT: fwdInt_r <= clampLim((DATA_W'(fwdInt_r) & ~beMask) | (avsWritedata & beMask));
        REG_REV_INT: revInt_r <= clampLim((DATA_W'(revInt_r) & ~beMask) | (avsWritedata & beMask));
        REG_FWD_EXT: fwdExt_r <= clampLim((DATA_W'(fwdExt_r) & ~beMask) | (avsWritedata & beMask));
        REG_REV_EXT: revExt_r <= clampLim((DATA_W'(revExt_r) & ~beMask) | (avsWritedata & beMask));
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky status, cleared by read, set wins over clear

  assign irqEvt[IRQ_LIM_BIT]  = limited_nxt & torqueLimitedN;
  assign irqEvt[IRQ_MODE_BIT] = (mode_nxt != activeMode);
  assign irqClr = (done && avsRead && avsAddress == REG_IRQ_STAT) ? '1 : '0;

  always_ff @(posedge clk) begin
    if (rst) begin
      irqStat_r <= '0;
    end else begin
      irqStat_r <= (irqStat_r & ~irqClr) | irqEvt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irqMask_r <= '0;
    end else if (wrEn && avsAddress == REG_IRQ_MASK) begin
      irqMask_r <= IRQ_W'((DATA_W'(irqMask_r) & ~beMask) | (avsWritedata & beMask));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irqStat_r & ~irqClr) | irqEvt) & irqMask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_fwd_min_select: assert property (funcOn[FN_FWD] |=>
    fwdTorqueLimit <= $past(fwdInt_r) && fwdTorqueLimit <= $past(fwdExt_r))
    else $error("forward limit above internal or external limit");
  a_fwd_internal_only: assert property (!funcOn[FN_FWD] |=>
    fwdTorqueLimit == $past(fwdInt_r))
    else $error("forward limit is not the internal limit");
  a_rev_min_select: assert property (funcOn[FN_REV] && analogUse |=>
    revTorqueLimit <= $past(analogLimit) && revTorqueLimit <= $past(revExt_r))
    else $error("reverse limit above analog or external limit");
  a_rev_internal_only: assert property (!funcOn[FN_REV] |=>
    revTorqueLimit == $past(revInt_r))
    else $error("reverse limit is not the internal limit");
  a_shared_terminal: assert property (funcIdx[FN_FWD] == funcIdx[FN_MSW]
    |-> funcOn[FN_FWD] == funcOn[FN_MSW])
    else $error("functions on one terminal disagree");
  a_clamp_flag: assert property (!reqNeg && reqMag > TREQ_W'(fwdTorqueLimit)
    |=> !torqueLimitedN ##1 1)
    else $error("clamped torque not flagged");
  a_clt_unmapped: assert property (outMap_r == 2'h0 |=> &outTermN)
    else $error("status on a terminal without mapping");
  a_ispd_leave: assert property (modePair_r == PAIR_ISPD_SPD && !spdMapped
    && !funcOn[FN_FWD] && !funcOn[FN_REV] |=> activeMode == MODE_SPEED)
    else $error("internal speed not left");
  a_spd_select: assert property ((modePair_r == PAIR_ISPD_POS || modePair_r == PAIR_ISPD_TRQ)
    && spdMapped
    && funcOn[FN_SPA] |=> activeMode == MODE_INT_SPEED)
    else $error("speed select ignored");
  a_switch_low: assert property (modePair_r == PAIR_POS_TRQ && funcOn[FN_ALT]
    |=> activeMode == MODE_TORQUE)
    else $error("alternate select low did not pick torque");
  a_switch_high: assert property (modePair_r == PAIR_TRQ_SPD && !funcOn[FN_MSW]
    && !funcOn[FN_ALT] |=> activeMode == MODE_TORQUE)
    else $error("switch high did not pick torque");
  a_zero_clamp: assert property (modePair_r == PAIR_SPD_ZCLMP && funcOn[FN_MSW]
    |=> activeMode == MODE_ZERO_CLAMP)
    else $error("switch low did not pick zero clamp");
  a_limit_range: assert property (fwdInt_r <= LIM_MAX && revExt_r <= LIM_MAX)
    else $error("limit parameter above 800");
  a_sync_depth: assert property (!$past(rst) && !$past(rst, 2)
    |-> termSync == $past(inTermN, 2))
    else $error("terminal not two cycles behind pin");
  a_bus_answer: assert property ((avsRead || avsWrite) && avsWaitrequest
    |=> !avsWaitrequest)
    else $error("waitrequest not released after one cycle");

  c_mode_torque: cover property (activeMode == MODE_POSITION ##1 activeMode == MODE_TORQUE);
  c_limited: cover property ($fell(torqueLimitedN) && outMap_r != 2'h0);
  c_irq_clear: cover property (irq ##1 irqClr != '0);

endmodule // cmts_limit_select
`default_nettype wire

// file: verification/cmts_host_model.sv
// Host controller model driving the active-low sequence terminals.
// Assumes the bench names the terminals to assert on onTerm, one bit a terminal.
`timescale 1ns/1ps
`default_nettype none
module cmts_host_model
  import cmts_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic [NUM_IN_TERM-1:0] onTerm,
  output var  logic [NUM_IN_TERM-1:0] inTermN
);
  // host terminal drive
  // Asserted terminals are pulled low just after an edge; sharing is the bench's choice
  always_ff @(posedge clk) begin
    inTermN <= ~onTerm;
  end
endmodule // cmts_host_model
`default_nettype wire

// file: verification/test_cmts_limit_select.sv
// Self-checking bench for the limit and mode selector.
// Assumes the host model on the terminals and an Avalon-MM master in the bench.
`timescale 1ns/1ps
`default_nettype none
module test_cmts_limit_select
  import cmts_pkg::*;
;
  logic                     clk = 1'b0;
  logic                     rst = 1'b1;
  logic [ADDR_W-1:0]        avsAddress = '0;
  logic                     avsRead = 1'b0;
  logic                     avsWrite = 1'b0;
  logic [DATA_W-1:0]        avsWritedata = '0;
  logic [DATA_W-1:0]        avsReaddata;
  logic                     avsWaitrequest;
  logic [NUM_IN_TERM-1:0]   onTerm = '0;
  logic [NUM_IN_TERM-1:0]   inTermN;
  logic [LIM_W-1:0]         analogLimit = '0;
  logic signed [TREQ_W-1:0] torqueReq = '0;
  logic [LIM_W-1:0]         fwdTorqueLimit;
  logic [LIM_W-1:0]         revTorqueLimit;
  cmts_mode_type            activeMode;
  logic                     torqueLimitedN;
  logic [NUM_OUT_TERM-1:0]  outTermN;
  logic                     irq;
  logic [31:0]              q;
  int                       fail_count = 0;
  int                       n_checks = 0;
  cmts_mode_type            loM [5] = '{MODE_SPEED, MODE_TORQUE, MODE_SPEED, MODE_ZERO_CLAMP,
                                        MODE_INHIBIT};
  cmts_mode_type            hiM [5] = '{MODE_POSITION, MODE_POSITION, MODE_TORQUE, MODE_SPEED,
                                        MODE_POSITION};
  logic [31:0]              rv [9] = '{32'h7, 32'h0, 32'h7021, 32'h77, 32'h0, 32'h320, 32'h320,
                                       32'h64, 32'h64};

  always #10 clk = ~clk;

  cmts_host_model cmts_host_model_inst (.clk(clk), .onTerm(onTerm), .inTermN(inTermN));
  cmts_limit_select cmts_limit_select_inst (
    .clk(clk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWritedata(avsWritedata), .avsByteenable(4'hf), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .inTermN(inTermN), .analogLimit(analogLimit),
    .torqueReq(torqueReq), .fwdTorqueLimit(fwdTorqueLimit), .revTorqueLimit(revTorqueLimit),
    .activeMode(activeMode), .torqueLimitedN(torqueLimitedN), .outTermN(outTermN), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One Avalon access, held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= w;
    avsRead <= ~w;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (avsWaitrequest === 1'b0) break;
    end
    q = avsReaddata;
    if (k == 20) begin
      fail_count++;
      close_out();
    end
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic pins(input logic [5:0] v);
    @(posedge clk);
    onTerm <= v;
    repeat (5) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) rdc(4'(i), rv[i]);
    rdc(4'he, 32'h0);
    chk({29'h0, outTermN}, 32'h7);
    $display("test reset done");
    acc(1'b1, REG_FWD_INT, 32'd300);
    acc(1'b1, REG_REV_INT, 32'd200);
    acc(1'b1, REG_FWD_EXT, 32'd900);
    rdc(REG_FWD_EXT, 32'h320);
    acc(1'b1, REG_FWD_EXT, 32'd500);
    pins(6'h0);
    chk(32'(fwdTorqueLimit), 32'd300);
    chk(32'(revTorqueLimit), 32'd200);
    analogLimit <= 10'd150;
    acc(1'b1, REG_SPEED_OPT, 32'h3);
    pins(6'h2);
    chk(32'(fwdTorqueLimit), 32'd150);
    acc(1'b1, REG_SPEED_OPT, 32'h0);
    pins(6'h6);
    chk(32'(fwdTorqueLimit), 32'd300);
    chk(32'(revTorqueLimit), 32'd100);
    rdc(REG_REV_ACT, 32'd100);
    $display("test limits done");
    acc(1'b1, REG_IRQ_MASK, 32'h1);
    rdc(REG_IRQ_MASK, 32'h1);
    acc(1'b0, REG_IRQ_STAT, 32'h0);
    torqueReq <= 12'sd400;
    pins(6'h6);
    chk({31'h0, torqueLimitedN}, 32'h0);
    chk({29'h0, outTermN}, 32'h7);
    chk({31'h0, irq}, 32'h1);
    acc(1'b1, REG_OUTPUT_MAP, 32'h2);
    pins(6'h6);
    chk({29'h0, outTermN}, 32'h5);
    rdc(REG_IRQ_STAT, 32'h1);
    pins(6'h6);
    chk({31'h0, irq}, 32'h0);
    torqueReq <= -12'sd150;
    pins(6'h6);
    chk({31'h0, torqueLimitedN}, 32'h0);
    torqueReq <= 12'sd50;
    pins(6'h6);
    chk({29'h0, outTermN}, 32'h7);
    torqueReq <= 12'sd400;
    pins(6'h6);
    chk({29'h0, outTermN}, 32'h5);
    $display("test limited done");
    for (int j = 0; j < 2; j++) begin
      if (j == 1) acc(1'b1, REG_INPUT_MAP, 32'h3021);
      for (int i = 0; i < 5; i++) begin
        acc(1'b1, REG_BASIC_FUNC, 32'(7 + i));
        pins(j == 0 ? 6'h1 : 6'h8);
        chk(32'(activeMode), 32'(loM[i]));
        pins(6'h0);
        chk(32'(activeMode), 32'(hiM[i]));
      end
    end
    acc(1'b1, REG_INPUT_MAP, 32'h7121);
    acc(1'b1, REG_BASIC_FUNC, 32'h7);
    pins(6'h2);
    chk(32'(activeMode), 32'(MODE_SPEED));
    acc(1'b1, REG_INPUT_MAP, 32'h7021);
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, REG_BASIC_FUNC, 32'(4 + i));
      pins(6'h0);
      chk(32'(activeMode), 32'(i == 0 ? MODE_SPEED : i == 1 ? MODE_POSITION : MODE_TORQUE));
      pins(6'h2);
      chk(32'(activeMode), 32'(MODE_INT_SPEED));
    end
    acc(1'b1, REG_SPSEL_MAP, 32'h74);
    pins(6'h0);
    chk(32'(activeMode), 32'(MODE_TORQUE));
    pins(6'h10);
    chk(32'(activeMode), 32'(MODE_INT_SPEED));
    rdc(REG_STATE, 32'h1010);
    $display("test modes done");
    close_out();
  end
endmodule // test_cmts_limit_select
`default_nettype wire
